// ### logic/mfg_pkg.sv
package mfg_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  MFG_ADDR_PIN_CFG    = 8'h24;
  localparam logic [7:0]  MFG_ADDR_DEV_MODE   = 8'h25;
  localparam logic [7:0]  MFG_PM_PAGE         = 8'hFF;
  localparam logic [7:0]  MFG_PM_PIN_CFG      = 8'hE8;
  localparam logic [7:0]  MFG_PM_DEV_MODE     = 8'hE9;
  localparam logic [15:0] MFG_RST_PIN_CFG     = 16'h0000;
  localparam logic [15:0] MFG_RST_DEV_MODE    = 16'h0000;

  // ------------------------------------------------------------------
  // Pin function control fields
  // ------------------------------------------------------------------
  localparam int MFG_FILT_EN_BIT   = 15;
  localparam int MFG_PIN_OE_BIT    = 13;
  localparam int MFG_OSEL_HI       = 12;
  localparam int MFG_OSEL_LO       = 9;
  localparam int MFG_CHSEL_HI      = 8;
  localparam int MFG_CHSEL_LO      = 5;
  localparam int MFG_IFUNC_HI      = 4;
  localparam int MFG_IFUNC_LO      = 1;
  localparam int MFG_PIN_IE_BIT    = 0;
  // Bit 14 is don't care; it is not stored and reads as zero.
  localparam logic [15:0] MFG_PIN_CFG_MASK = 16'hBFFF;

  // Bits of the channel-select field; channel 0 sits at the top.
  localparam int MFG_CHSEL_CH0     = 3;
  localparam int MFG_CHSEL_CH1     = 0;

  // ------------------------------------------------------------------
  // Device mode control fields
  // ------------------------------------------------------------------
  localparam int MFG_MODE_IN_DIS_BIT = 13;
  localparam int MFG_SHDN_HI         = 9;
  localparam int MFG_SHDN_LO         = 8;

  // ------------------------------------------------------------------
  // Output status select codes
  // ------------------------------------------------------------------
  localparam logic [3:0] MFG_OSEL_NONVOLATILE_BUSY = 4'h1;
  localparam logic [3:0] MFG_OSEL_CH1_BUSY = 4'h4;
  localparam logic [3:0] MFG_OSEL_CH0_BUSY = 4'h7;
  localparam logic [3:0] MFG_OSEL_CH1_WIN  = 4'h8;
  localparam logic [3:0] MFG_OSEL_CH0_WIN  = 4'hB;

  // ------------------------------------------------------------------
  // Input function codes
  // ------------------------------------------------------------------
  localparam logic [3:0] MFG_IF_FAULT_DUMP = 4'h2;
  localparam logic [3:0] MFG_IF_CUR_PWR    = 4'h3;
  localparam logic [3:0] MFG_IF_VOLT_PWR   = 4'h4;
  localparam logic [3:0] MFG_IF_SHUTDOWN   = 4'h5;
  localparam logic [3:0] MFG_IF_CLEAR      = 4'h7;
  localparam logic [3:0] MFG_IF_LOAD       = 4'h8;
  localparam logic [3:0] MFG_IF_FUNC_GEN   = 4'h9;
  localparam logic [3:0] MFG_IF_MARGIN     = 4'hA;
  localparam logic [3:0] MFG_IF_RESET      = 4'hB;
  localparam logic [3:0] MFG_IF_NVM_PROT   = 4'hC;
  localparam logic [3:0] MFG_IF_REG_LOCK   = 4'hD;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int MFG_CLK_PERIOD_NS  = 100;
  localparam int MFG_FILTER_TIME_NS = 300;
  localparam int MFG_FILTER_CYCLES  =
    (MFG_FILTER_TIME_NS + MFG_CLK_PERIOD_NS - 1) / MFG_CLK_PERIOD_NS;

endpackage

// ### logic/mfg_pin_filter.sv
`timescale 1ns/1ps
module mfg_pin_filter
  import mfg_pkg::*;
#(
  parameter int FILT_CYCLES = MFG_FILTER_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  input  wire logic i_pin,
  input  wire logic i_filt_en,
  output logic      o_level,
  output logic      o_valid
);

  // ------------------------------------------------------------------
  // Two-stage synchroniser
  // ------------------------------------------------------------------
  logic       sync1_q;
  logic       sync2_q;
  logic [7:0] cnt_q;
  logic [1:0] warm_q;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end

  // ------------------------------------------------------------------
  // Glitch filter
  // ------------------------------------------------------------------
  // A new level is taken only after it has been stable for the full
  // filter time; bypassing it trades robustness for latency.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_level <= 1'b1;
      cnt_q   <= 8'h00;
    end else if (!i_filt_en || sync2_q == o_level) begin
      o_level <= sync2_q;
      cnt_q   <= 8'h00;
    end else if (cnt_q >= 8'(FILT_CYCLES - 1)) begin
      o_level <= sync2_q;
      cnt_q   <= 8'h00;
    end else begin
      cnt_q   <= cnt_q + 8'h01;
    end
  end

  // The level is not trusted until the synchroniser has filled.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      warm_q <= 2'b00;
    end else if (warm_q != 2'b11) begin
      warm_q <= warm_q + 2'b01;
    end
  end

  assign o_valid = (warm_q == 2'b11);

endmodule // mfg_pin_filter

// ### logic/mfg_gpio.sv
`timescale 1ns/1ps
module mfg_gpio
  import mfg_pkg::*;
#(
  parameter int FILT_CYCLES = MFG_FILTER_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Register port from the serial host interface.
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_pm,
  input  wire logic [7:0]  i_reg_page,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic [15:0]      o_reg_rdata,
  output logic             o_reg_ack,
  // Status sources for output mode.
  input  wire logic        i_nonvolatile_busy,
  input  wire logic        i_ch0_busy,
  input  wire logic        i_ch1_busy,
  input  wire logic        i_channel0_window_result,
  input  wire logic        i_channel1_window_result,
  // Multifunction pin.
  input  wire logic        i_pin,
  output logic             o_pin,
  output logic             o_pin_oe,
  // Function triggers, index 0 is channel 0.
  output logic             o_fault_dump,
  output logic [1:0]       o_current_output_down,
  output logic [1:0]       o_current_output_up,
  output logic [1:0]       o_voltage_output_down,
  output logic [1:0]       o_voltage_output_up,
  output logic             o_shutdown_start,
  output logic             o_clear_input,
  output logic [1:0]       o_load_update_input,
  output logic [1:0]       o_func_gen_stop,
  output logic [1:0]       o_func_gen_start,
  output logic [1:0]       o_margin_low,
  output logic [1:0]       o_margin_high,
  output logic             o_device_reset,
  output logic             o_nvm_write_allow,
  output logic             o_reg_lock,
  // Device mode fields.
  output logic             o_mode_input_disable,
  output logic [1:0]       o_shutdown_mode
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Maps the channel-select field onto a channel vector, channel 0 low.
  function automatic logic [1:0] chan_mask(input logic [3:0] sel);
    chan_mask = {sel[MFG_CHSEL_CH1], sel[MFG_CHSEL_CH0]};
  endfunction

  // Decodes a register address in either the native or the
  // management-bus address space.
  function automatic logic addr_hit(input logic       pm,
                                    input logic [7:0] page,
                                    input logic [7:0] addr,
                                    input logic [7:0] nat,
                                    input logic [7:0] pmreg);
    if (pm) begin
      addr_hit = (page == MFG_PM_PAGE) && (addr == pmreg);
    end else begin
      addr_hit = (addr == nat);
    end
  endfunction

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  logic [15:0] pin_cfg_q;
  logic [15:0] dev_mode_q;
  logic        hit_pin;
  logic        hit_mode;
  logic        lock_q;

  assign hit_pin  = addr_hit(i_reg_pm, i_reg_page, i_reg_addr,
                             MFG_ADDR_PIN_CFG, MFG_PM_PIN_CFG);
  assign hit_mode = addr_hit(i_reg_pm, i_reg_page, i_reg_addr,
                             MFG_ADDR_DEV_MODE, MFG_PM_DEV_MODE);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_cfg_q <= MFG_RST_PIN_CFG;
    end else if (i_reg_wr && hit_pin && !lock_q) begin
      pin_cfg_q <= i_reg_wdata & MFG_PIN_CFG_MASK;
    end
  end

  // Reserved bits are kept as written so software reads back its value.
  // mode register storage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dev_mode_q <= MFG_RST_DEV_MODE;
    end else if (i_reg_wr && hit_mode && !lock_q) begin
      dev_mode_q <= i_reg_wdata;
    end
  end

  // Reads answer one cycle later; unmapped addresses read as zero.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack   <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_rd | i_reg_wr;
      if (i_reg_rd) begin
        if (hit_pin) begin
          o_reg_rdata <= pin_cfg_q;
        end else if (hit_mode) begin
          o_reg_rdata <= dev_mode_q;
        end else begin
          o_reg_rdata <= 16'h0000;
        end
      end
    end
  end

  assign o_shutdown_mode      = dev_mode_q[MFG_SHDN_HI:MFG_SHDN_LO];
  assign o_mode_input_disable = dev_mode_q[MFG_MODE_IN_DIS_BIT];

  // ------------------------------------------------------------------
  // Field views
  // ------------------------------------------------------------------
  logic       filt_en;
  logic       pin_oe_en;
  logic [3:0] out_sel;
  logic [1:0] chans;
  logic [3:0] in_func;
  logic       in_en;

  assign filt_en   = pin_cfg_q[MFG_FILT_EN_BIT];
  assign pin_oe_en = pin_cfg_q[MFG_PIN_OE_BIT];
  assign out_sel   = pin_cfg_q[MFG_OSEL_HI:MFG_OSEL_LO];
  assign chans     = chan_mask(pin_cfg_q[MFG_CHSEL_HI:MFG_CHSEL_LO]);
  assign in_func   = pin_cfg_q[MFG_IFUNC_HI:MFG_IFUNC_LO];
  assign in_en     = pin_cfg_q[MFG_PIN_IE_BIT];

  // ------------------------------------------------------------------
  // Output mode
  // ------------------------------------------------------------------
  logic out_bit;

  always_comb begin
    unique case (out_sel)
      MFG_OSEL_NONVOLATILE_BUSY: out_bit = i_nonvolatile_busy;
      MFG_OSEL_CH1_BUSY: out_bit = i_ch1_busy;
      MFG_OSEL_CH0_BUSY: out_bit = i_ch0_busy;
      MFG_OSEL_CH1_WIN:  out_bit = i_channel1_window_result;
      MFG_OSEL_CH0_WIN:  out_bit = i_channel0_window_result;
      default:           out_bit = 1'b0;
    endcase
  end

  // The pin value is registered so it cannot glitch while the select
  // field or the status sources change.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= out_bit;
    end
  end

  assign o_pin_oe = pin_oe_en;

  // ------------------------------------------------------------------
  // Input path
  // ------------------------------------------------------------------
  logic lvl;
  logic lvl_valid;
  logic lvl_prev_q;
  logic rise;
  logic fall;

  mfg_pin_filter #(
    .FILT_CYCLES (FILT_CYCLES)
  ) u_filter (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_pin     (i_pin),
    .i_filt_en (filt_en),
    .o_level   (lvl),
    .o_valid   (lvl_valid)
  );

  // The previous level follows the pin even while input mode is off, so
  // enabling input mode never fires a stale edge.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_prev_q <= 1'b1;
    end else if (lvl_valid) begin
      lvl_prev_q <= lvl;
    end
  end

  assign rise = lvl_valid && lvl && !lvl_prev_q;
  assign fall = lvl_valid && !lvl && lvl_prev_q;

  // ------------------------------------------------------------------
  // Function dispatch
  // ------------------------------------------------------------------
  logic act;
  logic fn_fault;
  logic fn_cur;
  logic fn_volt;
  logic fn_shdn;
  logic fn_load;
  logic fn_gen;
  logic fn_marg;

  assign act = in_en;

  assign fn_fault = act && (in_func == MFG_IF_FAULT_DUMP);
  assign fn_cur   = act && (in_func == MFG_IF_CUR_PWR);
  assign fn_volt  = act && (in_func == MFG_IF_VOLT_PWR);
  assign fn_shdn  = act && (in_func == MFG_IF_SHUTDOWN);
  assign fn_load  = act && (in_func == MFG_IF_LOAD);
  assign fn_gen   = act && (in_func == MFG_IF_FUNC_GEN);
  assign fn_marg  = act && (in_func == MFG_IF_MARGIN);

  // Global one-cycle triggers.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fault_dump     <= 1'b0;
      o_shutdown_start <= 1'b0;
    end else begin
      o_fault_dump     <= fn_fault && fall;
      o_shutdown_start <= fn_shdn && fall;
    end
  end

  // Per-channel one-cycle triggers.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_current_output_down <= 2'b00;
      o_current_output_up   <= 2'b00;
      o_voltage_output_down <= 2'b00;
      o_voltage_output_up   <= 2'b00;
      o_load_update_input   <= 2'b00;
      o_func_gen_stop       <= 2'b00;
      o_func_gen_start      <= 2'b00;
      o_margin_low          <= 2'b00;
      o_margin_high         <= 2'b00;
    end else begin
      o_current_output_down <= chans & {2{fn_cur && fall}};
      o_current_output_up   <= chans & {2{fn_cur && rise}};
      o_voltage_output_down <= chans & {2{fn_volt && fall}};
      o_voltage_output_up   <= chans & {2{fn_volt && rise}};
      o_load_update_input   <= chans & {2{fn_load && fall}};
      o_func_gen_stop       <= chans & {2{fn_gen && fall}};
      o_func_gen_start      <= chans & {2{fn_gen && rise}};
      o_margin_low          <= chans & {2{fn_marg && fall}};
      o_margin_high         <= chans & {2{fn_marg && rise}};
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_clear_input <= 1'b0;
    end else begin
      o_clear_input <= act && (in_func == MFG_IF_CLEAR) && lvl_valid && !lvl;
    end
  end

  // ------------------------------------------------------------------
  // Edge-set global states
  // ------------------------------------------------------------------
  // The device reset is held from the falling edge to the rising edge;
  // if the function is changed meanwhile, the reset is released so the
  // device cannot be left stuck in reset.
  // device reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_device_reset <= 1'b0;
    end else if (!(act && in_func == MFG_IF_RESET)) begin
      o_device_reset <= 1'b0;
    end else if (fall) begin
      o_device_reset <= 1'b1;
    end else if (rise) begin
      o_device_reset <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_nvm_write_allow <= 1'b0;
    end else if (act && in_func == MFG_IF_NVM_PROT) begin
      if (fall) begin
        o_nvm_write_allow <= 1'b1;
      end else if (rise) begin
        o_nvm_write_allow <= 1'b0;
      end
    end
  end

  // The lock also guards this block's own registers. Once locked, only
  // a falling edge unlocks them here; the unlock field lives elsewhere
  // and is exempted by the write path that owns it.
  // register map lock
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock_q <= 1'b0;
    end else if (act && in_func == MFG_IF_REG_LOCK) begin
      if (fall) begin
        lock_q <= 1'b0;
      end else if (rise) begin
        lock_q <= 1'b1;
      end
    end
  end

  assign o_reg_lock = lock_q;

endmodule // mfg_gpio

// ### testbench/mfg_gpio_sva.sv
`timescale 1ns/1ps
module mfg_gpio_sva
  import mfg_pkg::*;
#(
  parameter int FILT_CYCLES = MFG_FILTER_CYCLES
) (
  input wire logic        i_clk,
  input wire logic        i_arst_n,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic        i_reg_pm,
  input wire logic [7:0]  i_reg_page,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_pin,
  input wire logic        o_reg_ack,
  input wire logic        o_pin_oe,
  input wire logic        o_fault_dump,
  input wire logic [1:0]  o_margin_low,
  input wire logic        o_clear_input,
  input wire logic        o_reg_lock,
  input wire logic        o_mode_input_disable,
  input wire logic [1:0]  o_shutdown_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_pin_wr;
    i_reg_wr && !o_reg_lock && !i_reg_pm && i_reg_addr == MFG_ADDR_PIN_CFG;
  endsequence
  sequence s_pm_pin_wr;
    i_reg_wr && !o_reg_lock && i_reg_pm && i_reg_page == MFG_PM_PAGE
      && i_reg_addr == MFG_PM_PIN_CFG;
  endsequence
  sequence s_mode_wr;
    i_reg_wr && !o_reg_lock && (i_reg_pm ? (i_reg_page == MFG_PM_PAGE
      && i_reg_addr == MFG_PM_DEV_MODE) : i_reg_addr == MFG_ADDR_DEV_MODE);
  endsequence

  AST_REG_ACK:
    assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack) else $error("ack missing");
  AST_NO_ACK:
    assert property (!(i_reg_wr || i_reg_rd) |=> !o_reg_ack) else $error("stray ack");
  AST_OE_NATIVE:
    assert property (s_pin_wr |=> o_pin_oe == $past(i_reg_wdata[MFG_PIN_OE_BIT]))
      else $error("drive enable not taken");
  AST_OE_PM:
    assert property (s_pm_pin_wr |=> o_pin_oe == $past(i_reg_wdata[MFG_PIN_OE_BIT]))
      else $error("bus alias write lost");
  AST_OE_HOLD:
    assert property (!i_reg_wr |=> $stable(o_pin_oe)) else $error("drive enable moved");
  AST_MODE_WR:
    assert property (s_mode_wr |=>
      o_mode_input_disable == $past(i_reg_wdata[MFG_MODE_IN_DIS_BIT])
      && o_shutdown_mode == $past(i_reg_wdata[MFG_SHDN_HI:MFG_SHDN_LO]))
      else $error("mode write lost");
  AST_LOCK_DROP:
    assert property (i_reg_wr && o_reg_lock |=> $stable(o_pin_oe) && $stable(o_shutdown_mode))
      else $error("write passed lock");
  AST_FAULT_PULSE:
    assert property (o_fault_dump |=> !o_fault_dump) else $error("fault pulse too long");
  AST_MARGIN_PULSE:
    assert property (|o_margin_low |=> (o_margin_low == 2'h0) [*2])
      else $error("margin pulse repeated");
  AST_CLEAR_PIN:
    assert property ($rose(o_clear_input) |-> !$past(i_pin, 4)) else $error("clear without low");
endmodule // mfg_gpio_sva

// ### testbench/mfg_pin_partner.sv
`timescale 1ns/1ps
module mfg_pin_partner (
  input  wire logic i_clk,
  input  wire logic i_out,
  input  wire logic i_oe,
  output logic      o_line
);
  logic drv_q;
  initial drv_q = 1'b1;
  // The far side lets go of the line whenever the device drives it.
  assign o_line = i_oe ? i_out : drv_q;
  task automatic set_level(input logic lvl);
    drv_q = lvl;
  endtask
  task automatic pulse(input int n);
    drv_q = 1'b0;
    repeat (n) @(negedge i_clk);
    drv_q = 1'b1;
  endtask
endmodule // mfg_pin_partner

// ### testbench/test_multifunction_gpio_config.sv
`timescale 1ns/1ps
bind mfg_gpio mfg_gpio_sva #(.FILT_CYCLES(FILT_CYCLES)) u_sva (.i_clk, .i_arst_n, .i_reg_wr,
  .i_reg_rd, .i_reg_pm, .i_reg_page, .i_reg_addr, .i_reg_wdata, .i_pin, .o_reg_ack, .o_pin_oe,
  .o_fault_dump, .o_margin_low, .o_clear_input, .o_reg_lock, .o_mode_input_disable,
  .o_shutdown_mode);
module test_multifunction_gpio_config;
  import mfg_pkg::*;
  localparam logic [19:0] NONE = 20'h0_0000;
  logic        clk, arst_n, wr, rd, pm, pin_out, pin_oe, line;
  logic        fd, sd, clr, drst, nvm, lck, mid;
  logic [1:0]  cdn, cup, vdn, vup, ld, fgs, fgg, mlo, mhi, smode;
  logic [7:0]  page, addr;
  logic [15:0] wdata, rdata;
  logic [4:0]  stat;
  logic        ack;
  logic [19:0] seen_q;
  int          hits_q, num_errors, tests_run;
  wire  [19:0] trig = {fd, cdn, cup, vdn, vup, sd, ld, fgs, fgg, mlo, mhi};
  wire  [3:0]  lvl = {clr, drst, nvm, lck};
  logic [3:0]  osel [5] = '{MFG_OSEL_NONVOLATILE_BUSY, MFG_OSEL_CH1_BUSY, MFG_OSEL_CH0_BUSY,
                            MFG_OSEL_CH1_WIN, MFG_OSEL_CH0_WIN};

  mfg_gpio #(.FILT_CYCLES(3)) u_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_pm(pm),
    .i_reg_page(page), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .i_nonvolatile_busy(stat[4]), .i_ch1_busy(stat[3]),
    .i_ch0_busy(stat[2]), .i_channel1_window_result(stat[1]),
    .i_channel0_window_result(stat[0]), .i_pin(line), .o_pin(pin_out), .o_pin_oe(pin_oe),
    .o_fault_dump(fd), .o_current_output_down(cdn), .o_current_output_up(cup),
    .o_voltage_output_down(vdn), .o_voltage_output_up(vup), .o_shutdown_start(sd),
    .o_clear_input(clr), .o_load_update_input(ld), .o_func_gen_stop(fgs),
    .o_func_gen_start(fgg), .o_margin_low(mlo), .o_margin_high(mhi),
    .o_device_reset(drst), .o_nvm_write_allow(nvm), .o_reg_lock(lck),
    .o_mode_input_disable(mid), .o_shutdown_mode(smode));
  mfg_pin_partner u_far (.i_clk(clk), .i_out(pin_out), .i_oe(pin_oe), .o_line(line));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    seen_q <= seen_q | trig;
    if (trig != NONE) hits_q <= hits_q + 1;
  end

  // ----------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic p, input logic [7:0] a,
                     input logic [15:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    pm = p;
    addr = a;
    wdata = d;
    page = MFG_PM_PAGE;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    chk("ack", ack, 1'b1);
  endtask
  task automatic rdc(input logic p, input logic [7:0] a, input logic [15:0] exp);
    acc(1'b0, p, a, 16'h0000);
    chk("rdata", rdata, exp);
  endtask
  function automatic logic [15:0] cfg(input logic f, input logic [3:0] ch, input logic [3:0] c);
    return {f, 6'h00, ch, c, 1'h1};
  endfunction
  // Edge pair on the pin; the pin is assumed high on entry.
  task automatic run(input logic [15:0] c, input logic [19:0] ef, input logic [19:0] er,
                     input logic [3:0] lf, input logic [3:0] lr);
    acc(1'b1, 1'b0, MFG_ADDR_PIN_CFG, c);
    seen_q = NONE;
    hits_q = 0;
    u_far.set_level(1'b0);
    repeat (12) @(negedge clk);
    chk("fall", seen_q, ef);
    chk("fall hits", hits_q, ef != NONE);
    chk("fall lvl", lvl, lf);
    seen_q = NONE;
    hits_q = 0;
    u_far.set_level(1'b1);
    repeat (12) @(negedge clk);
    chk("rise", seen_q, er);
    chk("rise hits", hits_q, er != NONE);
    chk("rise lvl", lvl, lr);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #5_000_000;
    num_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, wr, rd, pm, page, addr, wdata, stat} = '0;
    {num_errors, tests_run, hits_q} = '0;
    seen_q = NONE;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    rdc(1'b0, MFG_ADDR_PIN_CFG, MFG_RST_PIN_CFG);
    rdc(1'b1, MFG_PM_DEV_MODE, MFG_RST_DEV_MODE);
    rdc(1'b0, 8'h30, 16'h0000);
    acc(1'b1, 1'b1, MFG_PM_PIN_CFG, 16'hFFFF);
    rdc(1'b1, MFG_PM_PIN_CFG, 16'hBFFF);
    rdc(1'b0, MFG_ADDR_PIN_CFG, 16'hBFFF);
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, 1'b1, MFG_PM_DEV_MODE, {2'h0, m[0], 3'h0, m[1:0], 8'h00});
      chk("shutdown mode", smode, m[1:0]);
      chk("mode in", mid, m[0]);
      rdc(1'b0, MFG_ADDR_DEV_MODE, {2'h0, m[0], 3'h0, m[1:0], 8'h00});
    end
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, 1'b0, MFG_ADDR_PIN_CFG, {3'h1, osel[i], 9'h000});
      stat = 5'h10 >> i;
      repeat (3) @(negedge clk);
      chk("status hi", line, 1'b1);
      stat = ~(5'h10 >> i);
      repeat (3) @(negedge clk);
      chk("status lo", line, 1'b0);
    end
    stat = 5'h1F;
    acc(1'b1, 1'b0, MFG_ADDR_PIN_CFG, {3'h1, 4'h2, 9'h000});
    repeat (3) @(negedge clk);
    chk("status na", line, 1'b0);
    chk("oe on", pin_oe, 1'b1);
    acc(1'b1, 1'b0, MFG_ADDR_PIN_CFG, 16'h0000);
    chk("oe off", pin_oe, 1'b0);
    chk("line", line, 1'b1);
    run(cfg(1'b0, 4'h9, MFG_IF_FAULT_DUMP), 20'h8_0000, NONE, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_CUR_PWR), 20'h6_0000, 20'h1_8000, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_VOLT_PWR), 20'h0_6000, 20'h0_1800, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_SHUTDOWN), 20'h0_0400, NONE, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_CLEAR), NONE, NONE, 4'h8, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_LOAD), 20'h0_0300, NONE, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_FUNC_GEN), 20'h0_00C0, 20'h0_0030, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_MARGIN), 20'h0_000C, 20'h0_0003, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h8, MFG_IF_MARGIN), 20'h0_0004, 20'h0_0001, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h1, MFG_IF_MARGIN), 20'h0_0008, 20'h0_0002, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_RESET), NONE, NONE, 4'h4, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_NVM_PROT), NONE, NONE, 4'h2, 4'h0);
    run(cfg(1'b0, 4'h9, 4'h6), NONE, NONE, 4'h0, 4'h0);
    run(cfg(1'b0, 4'h9, MFG_IF_SHUTDOWN) & 16'hFFFE, NONE, NONE, 4'h0, 4'h0);
    run(cfg(1'b1, 4'h9, MFG_IF_SHUTDOWN), 20'h0_0400, NONE, 4'h0, 4'h0);
    seen_q = NONE;
    u_far.pulse(1);
    repeat (12) @(negedge clk);
    chk("glitch", seen_q, NONE);
    run(cfg(1'b0, 4'h9, MFG_IF_REG_LOCK), NONE, NONE, 4'h0, 4'h1);
    acc(1'b1, 1'b0, MFG_ADDR_PIN_CFG, 16'h0000);
    rdc(1'b0, MFG_ADDR_PIN_CFG, cfg(1'b0, 4'h9, MFG_IF_REG_LOCK));
    u_far.set_level(1'b0);
    repeat (12) @(negedge clk);
    chk("unlock", lck, 1'b0);
    acc(1'b1, 1'b0, MFG_ADDR_PIN_CFG, 16'h0000);
    rdc(1'b0, MFG_ADDR_PIN_CFG, 16'h0000);
    end_sim();
  end
endmodule // test_multifunction_gpio_config
